/* design/twr_slave.sv */
// two-wire serial slave giving a bus master access to control registers
// What this block does
// - acts only as slave; never drives the clock line or starts transfers
// - data line changes only while clock low; changes while high are start/stop
// - data falling while clock high is a start; begins a new sequence
// - first byte is 7-bit address plus direction bit, 1 read, 0 write
// - lowest address bit follows strap pin; upper six bits fixed
// - acknowledge address match on ninth pulse; otherwise release and ignore
// - all bytes shift most significant bit first
// - withheld acknowledge leaves data line released high
// - master no-acknowledge on read ends data; release the line
// - first write byte after address loads the register pointer
// - pointer advances after each written byte, saturating at top register
// - no acknowledge for a pointer above the top register
// - reads start at pointer; pointer advances after each byte returned
// - stop is data rising while clock high; return to waiting for start
// - repeated start accepted without a preceding stop
`timescale 1ns/1ps
`include "twr_params.svh"
module twr_slave import twr_pkg::*; #(
    parameter int NREGS = `TWR_NUM_REGS
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_link_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic address_strap_pin_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic busy_o,
    output logic [NREGS-1:0][7:0] cfg_o
);
    logic [2:0] pins_s;
    logic scl_p_q;
    logic sda_p_q;
    twr_state_t st_q;
    twr_role_t role_q;
    logic [2:0] cnt_q;
    logic [7:0] shift_q;
    logic full_q;
    logic ack_q;
    logic rd_q;
    logic more_q;
    logic [`TWR_PTR_W-1:0] ptr_q;
    logic [7:0] regs_q [0:NREGS-1];
    twr_wr_t wr_q;
    logic wr_tgl_q;

    // scl and sda never reach logic before two flops
    twr_pin_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i({address_strap_pin_i, sda_i, scl_i}),
        .sync_o(pins_s)
    );

    wire scl_s = pins_s[0];
    wire sda_s = pins_s[1];
    wire strap_s = pins_s[2];
    wire start_w = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_w = scl_s & scl_p_q & ~sda_p_q & sda_s;
    wire scl_rise_w = scl_s & ~scl_p_q;
    wire scl_fall_w = ~scl_s & scl_p_q;
    wire [7:0] byte_w = {shift_q[6:0], sda_s};
    wire [6:0] my_addr_w = {`TWR_ADDR_HI6, strap_s};
    wire addr_hit_w = byte_w[7:1] == my_addr_w;
    wire ptr_ok_w = byte_w <= {3'h0, `TWR_REG_TOP};
    wire ack_w = (role_q == ROLE_ADDR) ? addr_hit_w :
                 (role_q == ROLE_PTR) ? ptr_ok_w : 1'b1;
    wire last_rx_w = st_q == ST_RX && scl_rise_w && cnt_q == 3'h7;
    wire wr_en_w = last_rx_w && role_q == ROLE_DATA;
    wire ptr_load_w = last_rx_w && role_q == ROLE_PTR && ptr_ok_w;
    wire tx_done_w = st_q == ST_TX && scl_fall_w && cnt_q == 3'h7;
    wire [`TWR_PTR_W-1:0] ptr_inc_w = (ptr_q == `TWR_REG_TOP) ? ptr_q :
                                      ptr_q + 5'h1;
    wire [7:0] rd_data_w = regs_q[ptr_q];

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // pointer only moves on accepted pointer bytes and completed data bytes
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_q <= '0;
        end else if (ptr_load_w) begin
            ptr_q <= byte_w[`TWR_PTR_W-1:0];
        end else if (wr_en_w || tx_done_w) begin
            ptr_q <= ptr_inc_w;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NREGS; i++) begin
                regs_q[i] <= `TWR_REG_RST;
            end
        end else if (wr_en_w) begin
            regs_q[ptr_q] <= byte_w;
        end
    end

    // event word stays put until the next byte, far longer than the crossing
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            wr_tgl_q <= 1'b0;
        end else if (wr_en_w) begin
            wr_q <= '{addr: ptr_q, data: byte_w};
            wr_tgl_q <= ~wr_tgl_q;
        end
    end

    twr_reg_mirror #(.NREGS(NREGS)) u_mirror (
        .clk_link_i(clk_link_i),
        .rst_n_i(rst_n_i),
        .wr_tgl_i(wr_tgl_q),
        .wr_i(wr_q),
        .cfg_o(cfg_o)
    );

    // sda only changes right after a falling clock edge, or is released on a start or stop
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= ST_IDLE;
            role_q <= ROLE_ADDR;
            cnt_q <= 3'h0;
            shift_q <= 8'h00;
            full_q <= 1'b0;
            ack_q <= 1'b0;
            rd_q <= 1'b0;
            more_q <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (start_w) begin
            st_q <= ST_RX;
            role_q <= ROLE_ADDR;
            cnt_q <= 3'h0;
            full_q <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (stop_w) begin
            st_q <= ST_IDLE;
            sda_oe_o <= 1'b0;
        end else begin
            case (st_q)
                ST_RX: begin
                    if (scl_rise_w) begin
                        shift_q <= byte_w;
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            full_q <= 1'b1;
                            ack_q <= ack_w;
                            if (role_q == ROLE_ADDR) begin
                                rd_q <= sda_s;
                            end
                        end
                    end else if (scl_fall_w && full_q) begin
                        full_q <= 1'b0;
                        st_q <= ST_ACK;
                        sda_oe_o <= ack_q;
                    end
                end
                ST_ACK: begin
                    if (scl_fall_w) begin
                        cnt_q <= 3'h0;
                        if (!ack_q) begin
                            st_q <= ST_IGNORE;
                            sda_oe_o <= 1'b0;
                        end else if (role_q == ROLE_ADDR && rd_q) begin
                            st_q <= ST_TX;
                            shift_q <= rd_data_w;
                            sda_oe_o <= ~rd_data_w[7];
                        end else begin
                            st_q <= ST_RX;
                            role_q <= (role_q == ROLE_ADDR) ? ROLE_PTR : ROLE_DATA;
                            sda_oe_o <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall_w) begin
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            st_q <= ST_MACK;
                            more_q <= 1'b0;
                            sda_oe_o <= 1'b0;
                        end else begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            sda_oe_o <= ~shift_q[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise_w) begin
                        more_q <= ~sda_s;
                    end else if (scl_fall_w) begin
                        if (more_q) begin
                            st_q <= ST_TX;
                            shift_q <= rd_data_w;
                            sda_oe_o <= ~rd_data_w[7];
                        end else begin
                            st_q <= ST_IGNORE;
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    sda_oe_o <= 1'b0;
                end
                default: begin
                    st_q <= ST_IDLE;
                    sda_oe_o <= 1'b0;
                end
            endcase
        end
    end

    // open drain: only ever pulls low, scl is input only
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            busy_o <= st_q != ST_IDLE && st_q != ST_IGNORE;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    idle_release_a: assert property (
        (st_q == ST_IDLE || st_q == ST_IGNORE) && $past(st_q) == st_q |-> !sda_oe_o)
        else $error("sda driven while idle or ignoring");
    ack_drive_a: assert property (
        last_rx_w && role_q == ROLE_ADDR && addr_hit_w && !start_w && !stop_w
        |=> (ack_q && full_q) ##[1:300] (st_q == ST_ACK && sda_oe_o))
        else $error("address match not acknowledged");
    nack_release_a: assert property (
        st_q == ST_ACK && !ack_q |-> !sda_oe_o)
        else $error("sda pulled during withheld acknowledge");
    start_resets_a: assert property (
        start_w |=> st_q == ST_RX && cnt_q == 3'h0 && role_q == ROLE_ADDR && !sda_oe_o)
        else $error("start did not restart address phase");
    stop_idle_a: assert property (
        stop_w |=> st_q == ST_IDLE && !sda_oe_o)
        else $error("stop did not return to idle");
    ptr_step_a: assert property (
        (wr_en_w || tx_done_w) && !ptr_load_w |=>
        ptr_q == (($past(ptr_q) == `TWR_REG_TOP) ? `TWR_REG_TOP : $past(ptr_q) + 5'h1))
        else $error("pointer did not advance or saturate");
    tx_msb_a: assert property (
        st_q == ST_TX |-> sda_oe_o == !shift_q[7])
        else $error("transmit bit not the top shift bit");
    mnack_end_a: assert property (
        st_q == ST_MACK && scl_fall_w && !more_q && !start_w && !stop_w
        |=> st_q == ST_IGNORE && !sda_oe_o)
        else $error("master no-acknowledge did not end read");
    ptr_nack_a: assert property (
        last_rx_w && role_q == ROLE_PTR && !ptr_ok_w && !start_w && !stop_w
        |=> !ack_q && $stable(ptr_q))
        else $error("out-of-range pointer accepted");

    // a foreign address must never see our acknowledge
    addr_miss_a: assert property (
        last_rx_w && role_q == ROLE_ADDR && !addr_hit_w && !start_w && !stop_w
        |=> !ack_q && full_q)
        else $error("foreign address acknowledged");

    ignore_hold_a: assert property (
        st_q == ST_IGNORE && !start_w && !stop_w |=> st_q == ST_IGNORE)
        else $error("ignore state left without start or stop");

    dir_bit_a: assert property (
        last_rx_w && role_q == ROLE_ADDR && !start_w && !stop_w |=> rd_q == $past(sda_s))
        else $error("direction bit not taken from eighth bit");

    ptr_load_a: assert property (
        ptr_load_w |=> ptr_q == $past(byte_w[`TWR_PTR_W-1:0]))
        else $error("pointer byte not loaded");

    reg_store_a: assert property (
        wr_en_w |=> regs_q[$past(ptr_q)] == $past(byte_w))
        else $error("data byte not stored at pointer");

    // drive changes right after a seen clock fall, or releases on a start or stop while clock high
    sda_change_a: assert property (
        $changed(sda_oe_o) |-> $past(scl_fall_w || start_w || stop_w))
        else $error("sda drive changed outside clock low");
endmodule : twr_slave

/* design/twr_params.svh */
// constants for the two-wire register access slave
`ifndef TWR_PARAMS_SVH
`define TWR_PARAMS_SVH

`define TWR_NUM_REGS 26
`define TWR_REG_TOP 5'h19
`define TWR_PTR_W 5
`define TWR_ADDR_HI6 6'h26
`define TWR_REG_RST 8'h00
`define TWR_SYNC_STAGES 2

`endif

/* design/twr_pkg.sv */
// types shared by the two-wire register access slave
package twr_pkg;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_RX     = 6'h02,
        ST_ACK    = 6'h04,
        ST_TX     = 6'h08,
        ST_MACK   = 6'h10,
        ST_IGNORE = 6'h20
    } twr_state_t;

    typedef enum logic [2:0] {
        ROLE_ADDR = 3'h1,
        ROLE_PTR  = 3'h2,
        ROLE_DATA = 3'h4
    } twr_role_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] data;
    } twr_wr_t;

endpackage : twr_pkg

/* design/twr_pin_sync.sv */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module twr_pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= pin_i;
            sync_o <= meta_q;
        end
    end
endmodule : twr_pin_sync

/* design/twr_reg_mirror.sv */
// register copy in the link domain, loaded by toggle handshake
`timescale 1ns/1ps
`include "twr_params.svh"
module twr_reg_mirror import twr_pkg::*; #(
    parameter int NREGS = `TWR_NUM_REGS
) (
    input wire logic clk_link_i,
    input wire logic rst_n_i,
    input wire logic wr_tgl_i,
    input wire twr_wr_t wr_i,
    output logic [NREGS-1:0][7:0] cfg_o
);
    logic tgl_meta_q;
    logic tgl_sync_q;
    logic tgl_seen_q;
    wire tgl_evt_w = tgl_sync_q ^ tgl_seen_q;

    // wr_i is held stable by the sender for a whole byte time
    always_ff @(posedge clk_link_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tgl_meta_q <= 1'b0;
            tgl_sync_q <= 1'b0;
            tgl_seen_q <= 1'b0;
        end else begin
            tgl_meta_q <= wr_tgl_i;
            tgl_sync_q <= tgl_meta_q;
            tgl_seen_q <= tgl_sync_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NREGS; g++) begin : g_reg
            always_ff @(posedge clk_link_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cfg_o[g] <= `TWR_REG_RST;
                end else if (tgl_evt_w && wr_i.addr == 5'(g)) begin
                    cfg_o[g] <= wr_i.data;
                end
            end
        end
    endgenerate

    mirror_load_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
        tgl_evt_w |=> cfg_o[wr_i.addr] == $past(wr_i.data))
        else $error("mirror register not loaded");
endmodule : twr_reg_mirror

/* verif/twr_bus_master.sv */
// two-wire bus master model driving the clock and data lines
`timescale 1ns/1ps
module twr_bus_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic pause(input int n);
        repeat (n) @(negedge clk_i);
    endtask : pause

    // from a low clock this is a repeated start
    task automatic bus_start;
        if (!scl_o) begin
            sda_low_o = 1'b0;
            pause(4);
            scl_o = 1'b1;
            pause(8);
        end
        sda_low_o = 1'b1;
        pause(8);
        scl_o = 1'b0;
        pause(4);
    endtask : bus_start

    task automatic bus_stop;
        sda_low_o = 1'b1;
        pause(4);
        scl_o = 1'b1;
        pause(8);
        sda_low_o = 1'b0;
        pause(8);
    endtask : bus_stop

    // data moves only while the clock is low, sampled mid-high
    task automatic bit_xfer(input logic b, output logic r);
        sda_low_o = ~b;
        pause(4);
        scl_o = 1'b1;
        pause(4);
        r = sda_i;
        pause(4);
        scl_o = 1'b0;
        pause(4);
    endtask : bit_xfer

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask : put_byte

    task automatic get_byte(input logic mack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            b[i] = r;
        end
        bit_xfer(~mack, r);
    endtask : get_byte
endmodule : twr_bus_master

/* verif/two_wire_register_access_slave_tb.sv */
// self-checking bench for the two-wire register access slave
`timescale 1ns/1ps
`include "twr_params.svh"
module two_wire_register_access_slave_tb import twr_pkg::*;;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b1;
    logic rst_n = 1'b0;
    logic strap = 1'b0;
    logic scl, m_low, sda_o_w, sda_oe, busy, sda_line;
    logic [`TWR_NUM_REGS-1:0][7:0] cfg;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;

    always #10 clk_sys = ~clk_sys;
    always #7.5 clk_link = ~clk_link;
    // open-drain wire with pull-up
    assign sda_line = m_low ? 1'b0 : (sda_oe ? sda_o_w : 1'b1);

    twr_slave twr_slave_i (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .clk_link_i(clk_link),
        .scl_i(scl), .sda_i(sda_line), .address_strap_pin_i(strap), .sda_o(sda_o_w),
        .sda_oe_o(sda_oe), .busy_o(busy), .cfg_o(cfg));
    twr_bus_master twr_bus_master_i (.clk_i(clk_sys), .sda_i(sda_line), .scl_o(scl),
        .sda_low_o(m_low));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic print_verdict;
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic addr_phase(input logic rw);
        logic a;
        twr_bus_master_i.bus_start();
        twr_bus_master_i.put_byte({`TWR_ADDR_HI6, strap, rw}, a);
        chk("addr ack", 8'h01, {7'h00, a});
    endtask : addr_phase

    task automatic put(input logic [7:0] b, input logic exp_ack);
        logic a;
        twr_bus_master_i.put_byte(b, a);
        chk("byte ack", {7'h00, exp_ack}, {7'h00, a});
    endtask : put

    task automatic rd(input logic mack, input logic [7:0] exp);
        logic [7:0] b;
        twr_bus_master_i.get_byte(mack, b);
        chk("read data", exp, b);
    endtask : rd

    task automatic t_write_read;
        addr_phase(1'b0);
        put(8'h03, 1'b1);
        put(8'ha5, 1'b1);
        put(8'h3c, 1'b1);
        addr_phase(1'b0);
        put(8'h03, 1'b1);
        addr_phase(1'b1);
        rd(1'b1, 8'ha5);
        rd(1'b0, 8'h3c);
        twr_bus_master_i.bus_stop();
        chk("busy after stop", 8'h00, {7'h00, busy});
        twr_bus_master_i.pause(20);
        chk("mirror 03", 8'ha5, cfg[3]);
        chk("mirror 04", 8'h3c, cfg[4]);
    endtask : t_write_read

    task automatic t_saturate;
        addr_phase(1'b0);
        put(8'h18, 1'b1);
        put(8'h11, 1'b1);
        put(8'h22, 1'b1);
        put(8'h33, 1'b1);
        twr_bus_master_i.bus_stop();
        addr_phase(1'b0);
        put(8'h18, 1'b1);
        twr_bus_master_i.bus_stop();
        addr_phase(1'b1);
        rd(1'b1, 8'h11);
        rd(1'b1, 8'h33);
        rd(1'b0, 8'h33);
        twr_bus_master_i.bus_stop();
        twr_bus_master_i.pause(20);
        chk("mirror top", 8'h33, cfg[`TWR_NUM_REGS-1]);
    endtask : t_saturate

    task automatic t_bad_ptr;
        addr_phase(1'b0);
        put(8'h1a, 1'b0);
        put(8'h55, 1'b0);
        chk("busy ignoring", 8'h00, {7'h00, busy});
        twr_bus_master_i.bus_stop();
        addr_phase(1'b1);
        rd(1'b0, 8'h33);
        twr_bus_master_i.bus_stop();
    endtask : t_bad_ptr

    task automatic t_read_nack;
        logic r;
        addr_phase(1'b0);
        put(8'h03, 1'b1);
        addr_phase(1'b1);
        rd(1'b0, 8'ha5);
        twr_bus_master_i.bit_xfer(1'b1, r);
        chk("released after nack", 8'h01, {7'h00, r});
        chk("busy after nack", 8'h00, {7'h00, busy});
        twr_bus_master_i.bus_stop();
    endtask : t_read_nack

    task automatic t_strap;
        logic a;
        strap = 1'b1;
        twr_bus_master_i.pause(6);
        twr_bus_master_i.bus_start();
        twr_bus_master_i.put_byte({`TWR_ADDR_HI6, 1'b0, 1'b0}, a);
        chk("other address", 8'h00, {7'h00, a});
        put(8'h00, 1'b0);
        twr_bus_master_i.bus_stop();
        addr_phase(1'b0);
        put(8'h00, 1'b1);
        put(8'h7e, 1'b1);
        twr_bus_master_i.bus_stop();
        twr_bus_master_i.pause(20);
        chk("mirror 00", 8'h7e, cfg[0]);
        strap = 1'b0;
        twr_bus_master_i.pause(6);
    endtask : t_strap

    // hang guard, well above the few thousand cycles the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            chk("timeout", 8'h00, 8'h01);
            print_verdict();
        end
    end

    initial begin
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        for (int i = 0; i < `TWR_NUM_REGS; i++) begin
            chk("reset value", `TWR_REG_RST, cfg[i]);
        end
        chk("busy at reset", 8'h00, {7'h00, busy});
        t_write_read();
        t_saturate();
        t_bad_ptr();
        t_read_nack();
        t_strap();
        print_verdict();
    end
endmodule : two_wire_register_access_slave_tb
